// file: pkg/power_reset_params.svh
// offsets, field positions, reset values and timing counts of the power/reset block
// assumes a 12-bit APB byte address and 8-bit registers in the low data lane
`ifndef POWER_RESET_PARAMS_SVH
`define POWER_RESET_PARAMS_SVH

// register indices; byte address is four times the index
`define SLEEP_CTRL_IDX 10'h033
`define CLK_GATE_IDX 10'h034
`define BOD_CTRL_IDX 10'h035
`define STATUS_IDX 10'h036

// reset values
`define SLEEP_CTRL_RST 8'h00
`define CLK_GATE_RST 8'h00
`define BOD_CTRL_RST 8'h00

// sleep control fields
`define SE_BIT 0
`define MODE_LSB 1

// brown-out sleep control fields
`define BROWNOUT_SLEEP_OFF_BIT 6
`define UNLOCK_BIT 5

// clock gating fields
`define GATE_CONV 0
`define GATE_UART 1
`define GATE_SPI 2
`define GATE_TIM1 3
`define GATE_TIM0 5
`define GATE_TIM2 6
`define GATE_TWI 7
`define GATE_MASK 8'hEF

// timed sequence
`define UNLOCK_WINDOW 3'h4
`define BROWNOUT_SLEEP_OFF_DELAY 3'h3
`define BROWNOUT_SLEEP_OFF_HOLD 3'h3
`define BROWNOUT_SLEEP_OFF_END (`BROWNOUT_SLEEP_OFF_DELAY + `BROWNOUT_SLEEP_OFF_HOLD - 3'h1)

// brown-out detector fuse code meaning detector off
`define BOD_FUSE_OFF 3'h7

// timing
`define CLK_PERIOD_PS 5000
`define BOD_MIN_TIME_NS 2000
`define BOD_MIN_CYCLES ((`BOD_MIN_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: pkg/power_reset_pkg.sv
// types of the sleep, power and reset control block
// assumes power_reset_params.svh for all numeric constants
package power_reset_pkg;

	typedef enum logic [2:0] {
		MODE_IDLE = 3'b000,
		MODE_CONV_QUIET = 3'b001,
		MODE_POWER_DOWN = 3'b010,
		MODE_POWER_SAVE = 3'b011,
		MODE_RSVD_A = 3'b100,
		MODE_RSVD_B = 3'b101,
		MODE_STANDBY = 3'b110,
		MODE_EXT_STANDBY = 3'b111
	} sleep_mode_e;

	typedef enum logic {
		PWR_ACTIVE = 1'b0,
		PWR_ASLEEP = 1'b1
	} pwr_state_e;

	typedef struct packed {
		sleep_mode_e mode;
		logic sleep_en;
		logic [7:0] gate;
		logic [2:0] unlock_cnt;
		logic brownout_sleep_off;
		logic [2:0] brownout_sleep_off_age;
		pwr_state_e pstate;
		logic bod_off;
		sleep_mode_e slept_mode;
		logic [15:0] bod_cnt;
		logic bod_rst;
		logic [7:0] rdata;
		logic slverr;
	} ctrl_s;

	typedef struct packed {
		logic [1:0] rel;
		logic [15:0] cnt;
		logic busy;
	} stretch_s;

	typedef struct packed {
		logic meta;
		logic stable;
	} sync_s;

endpackage

// file: logic/sync_two_ff.sv
// two-flop synchroniser for one level from outside the pclk domain
// assumes the level changes slower than the clock
`timescale 1ns/1ps
module sync_two_ff
	import power_reset_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// level
	input wire logic din,
	output logic dout
);
	sync_s r;
	sync_s n;

	always_comb begin
		n = r;
		n.meta = din;
		n.stable = r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign dout = r.stable;
endmodule

// file: logic/reset_stretch.sv
// delay counter that holds the internal reset after all sources go quiet
// assumes raw_reset_n is a glitch-free combination of the reset sources
`timescale 1ns/1ps
module reset_stretch
	import power_reset_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// reset sources, active low, asynchronous
	input wire logic raw_reset_n,
	// static timeout from fuse decode
	input wire logic [15:0] timeout_cycles,
	// stretched reset
	output logic core_reset
);
	stretch_s r;
	stretch_s n;
	logic arst_n;

	// any source asserts the stretched reset with no clock at all
	assign arst_n = presetn & raw_reset_n;

	always_comb begin
		n = r;
		n.rel = {r.rel[0], 1'b1};
		if (r.rel[1] && r.busy) begin
			if (r.cnt >= timeout_cycles) begin
				n.busy = 1'b0;
			end else begin
				n.cnt = r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{rel: 2'b00, cnt: 16'h0000, busy: 1'b1};
		end else begin
			r <= n;
		end
	end

	assign core_reset = r.busy;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!arst_n);

	property p_release_after_count;
		$fell(r.busy) |-> ($past(r.cnt) >= timeout_cycles) && $past(r.rel[1]);
	endproperty
	a_release_after_count: assert property (p_release_after_count)
		else $error("internal reset released before the timeout");
endmodule

// file: logic/sleep_power_reset_control.sv
// sleep mode control, brown-out sleep unlock, clock gating and reset generation
// assumes an APB master on pclk and analog/pin reset sources arriving asynchronously
//
// Functional notes
// - reserved bits of sleep control and clock gating registers read zero.
// - three-bit mode field picks idle, quiet, down, save, standby, extended.
// - sleep instruction sleeps only while sleep enable bit is one.
// - sleep-off bit set only by unlock write then commit within four cycles.
// - sleep-off active three cycles after set, cleared three cycles later.
// - detector off during a sleep only if sleep starts while sleep-off active.
// - gating bits stop two-wire, serial peripheral and UART clocks.
// - timer two gating acts only with its synchronous clock selected.
// - timer zero and one gated, resume from frozen state when enabled.
// - converter gated only when disabled; gated converter blocks comparator mux.
// - reset loads every register with its initial value.
// - ports reset at once from power-on, pin or watchdog, without a clock; brown-out passes a clocked filter.
// - delay counter holds internal reset after every source goes inactive.
// - four reset sources: power-on, pin, watchdog, enabled brown-out.
// - power-on drop reasserts internal reset with no delay.
// - long low pin resets without clock; a fuse disables the pin.
// - brown-out low asserts reset; release through the delay counter.
// - brown-out dips shorter than the minimum duration are ignored.
`timescale 1ns/1ps
`include "power_reset_params.svh"
module sleep_power_reset_control
	import power_reset_pkg::*;
#(
	parameter int unsigned BOD_MIN_CYCLES = `BOD_MIN_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire logic sleep_instr,
	input wire logic wake_event,
	input wire logic watchdog_reset_pulse,
	input wire logic timer_two_async_select,
	input wire logic converter_enabled,
	// analog detectors and reset pin
	input wire logic por_active,
	input wire logic ext_reset_pin_n,
	input wire logic brownout_low,
	// fuses
	input wire logic external_reset_disable_fuse,
	input wire logic [2:0] brownout_level_fuse,
	input wire logic [15:0] startup_timeout_cycles,
	// reset outputs
	output logic core_reset,
	output logic port_reset,
	// sleep outputs
	output logic sleep_active,
	output logic [2:0] sleep_mode,
	output logic brownout_detector_enable,
	// peripheral clock enables
	output logic two_wire_clk_en,
	output logic timer_two_clk_en,
	output logic timer_zero_clk_en,
	output logic timer_one_clk_en,
	output logic serial_periph_clk_en,
	output logic uart_zero_clk_en,
	output logic converter_clk_en,
	output logic comparator_mux_allow
);
	localparam logic [15:0] BOD_MIN = 16'(BOD_MIN_CYCLES);

	if (BOD_MIN_CYCLES < 1 || BOD_MIN_CYCLES > 65535) begin : g_bad_min
		$error("BOD_MIN_CYCLES must lie in 1..65535");
	end

	ctrl_s r;
	ctrl_s n;
	logic setup;
	logic wr_acc;
	logic aligned;
	logic hit_sleep;
	logic hit_gate;
	logic hit_bod;
	logic hit_stat;
	logic hit_any;
	logic window_open;
	logic brownout_sleep_off_active;
	logic fuse_bod_en;
	logic bod_low_sync;
	logic ext_reset_act;
	logic raw_reset_n;
	logic mode_reserved;

	sync_two_ff u_bod_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(brownout_low),
		.dout(bod_low_sync)
	);

	// pin and power-on detector paths are combinational so they need no running clock
	assign ext_reset_act = ~ext_reset_pin_n & ~external_reset_disable_fuse;
	assign raw_reset_n = ~(por_active | ext_reset_act | watchdog_reset_pulse
		| r.bod_rst);
	assign port_reset = ~raw_reset_n;

	reset_stretch u_stretch (
		.pclk(pclk),
		.presetn(presetn),
		.raw_reset_n(raw_reset_n),
		.timeout_cycles(startup_timeout_cycles),
		.core_reset(core_reset)
	);

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign aligned = (paddr[1:0] == 2'b00);
	assign hit_sleep = aligned && (paddr[11:2] == `SLEEP_CTRL_IDX);
	assign hit_gate = aligned && (paddr[11:2] == `CLK_GATE_IDX);
	assign hit_bod = aligned && (paddr[11:2] == `BOD_CTRL_IDX);
	assign hit_stat = aligned && (paddr[11:2] == `STATUS_IDX);
	assign hit_any = hit_sleep | hit_gate | hit_bod | hit_stat;

	assign window_open = (r.unlock_cnt != 3'h0);
	assign brownout_sleep_off_active = r.brownout_sleep_off && (r.brownout_sleep_off_age >= `BROWNOUT_SLEEP_OFF_DELAY);
	assign fuse_bod_en = (brownout_level_fuse != `BOD_FUSE_OFF);
	assign mode_reserved = (r.mode == MODE_RSVD_A) || (r.mode == MODE_RSVD_B);

	always_comb begin
		n = r;
		if (window_open) begin
			n.unlock_cnt = r.unlock_cnt - 3'h1;
		end
		// sleep-off bit ages and clears itself
		if (r.brownout_sleep_off) begin
			if (r.brownout_sleep_off_age == `BROWNOUT_SLEEP_OFF_END) begin
				n.brownout_sleep_off = 1'b0;
				n.brownout_sleep_off_age = 3'h0;
			end else begin
				n.brownout_sleep_off_age = r.brownout_sleep_off_age + 3'h1;
			end
		end
		if (wr_acc && hit_sleep) begin
			n.sleep_en = pwdata[`SE_BIT];
			n.mode = sleep_mode_e'(pwdata[`MODE_LSB +: 3]);
		end
		if (wr_acc && hit_gate) begin
			n.gate = pwdata[7:0] & `GATE_MASK;
			// refuse to gate a converter that is still running
			n.gate[`GATE_CONV] = pwdata[`GATE_CONV]
				& (r.gate[`GATE_CONV] | ~converter_enabled);
		end
		if (wr_acc && hit_bod && pwdata[`BROWNOUT_SLEEP_OFF_BIT]) begin
			if (pwdata[`UNLOCK_BIT]) begin
				n.unlock_cnt = `UNLOCK_WINDOW;
			end else if (window_open) begin
				n.brownout_sleep_off = 1'b1;
				n.brownout_sleep_off_age = 3'h0;
				n.unlock_cnt = 3'h0;
			end
		end
		case (r.pstate)
			PWR_ACTIVE: begin
				// reserved encodings are treated as no sleep
				if (sleep_instr && r.sleep_en && !mode_reserved) begin
					n.pstate = PWR_ASLEEP;
					n.slept_mode = r.mode;
					n.bod_off = brownout_sleep_off_active;
				end
			end
			PWR_ASLEEP: begin
				if (wake_event) begin
					n.pstate = PWR_ACTIVE;
					n.bod_off = 1'b0;
				end
			end
			default: begin
				n.pstate = PWR_ACTIVE;
			end
		endcase
		// brown-out filter; a detector switched off in sleep cannot trip
		if (fuse_bod_en && !r.bod_off && bod_low_sync) begin
			if (r.bod_cnt != BOD_MIN) begin
				n.bod_cnt = r.bod_cnt + 16'h0001;
			end
		end else begin
			n.bod_cnt = 16'h0000;
		end
		n.bod_rst = (n.bod_cnt == BOD_MIN);
		if (setup) begin
			n.slverr = ~hit_any;
			n.rdata = 8'h00;
			if (hit_sleep) begin
				n.rdata = {4'h0, r.mode, r.sleep_en};
			end
			if (hit_gate) begin
				n.rdata = r.gate & `GATE_MASK;
			end
			if (hit_bod) begin
				n.rdata[`BROWNOUT_SLEEP_OFF_BIT] = r.brownout_sleep_off;
				n.rdata[`UNLOCK_BIT] = window_open;
			end
			if (hit_stat) begin
				n.rdata = {4'h0, r.bod_off, brownout_sleep_off_active, r.bod_rst, r.pstate == PWR_ASLEEP};
			end
		end
		// internal reset reloads control state; filter is kept so it cannot loop
		if (core_reset) begin
			n.mode = sleep_mode_e'(3'(`SLEEP_CTRL_RST >> `MODE_LSB));
			n.sleep_en = 1'(`SLEEP_CTRL_RST >> `SE_BIT);
			n.gate = `CLK_GATE_RST;
			n.unlock_cnt = 3'h0;
			n.brownout_sleep_off = 1'b0;
			n.brownout_sleep_off_age = 3'h0;
			n.pstate = PWR_ACTIVE;
			n.bod_off = 1'b0;
			n.slept_mode = MODE_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pready = 1'b1;
	assign prdata = {24'h000000, r.rdata};
	assign pslverr = psel & penable & r.slverr;

	assign sleep_active = (r.pstate == PWR_ASLEEP);
	assign sleep_mode = r.slept_mode;
	assign brownout_detector_enable = fuse_bod_en & ~r.bod_off;

	// clocks stop, state is frozen, nothing is reset
	assign two_wire_clk_en = ~r.gate[`GATE_TWI];
	assign serial_periph_clk_en = ~r.gate[`GATE_SPI];
	assign uart_zero_clk_en = ~r.gate[`GATE_UART];
	assign timer_two_clk_en = ~(r.gate[`GATE_TIM2] & ~timer_two_async_select);
	assign timer_zero_clk_en = ~r.gate[`GATE_TIM0];
	assign timer_one_clk_en = ~r.gate[`GATE_TIM1];
	assign converter_clk_en = ~r.gate[`GATE_CONV];
	assign comparator_mux_allow = ~r.gate[`GATE_CONV];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_unlock;
		wr_acc && hit_bod && pwdata[`BROWNOUT_SLEEP_OFF_BIT] && pwdata[`UNLOCK_BIT] && !core_reset;
	endsequence

	sequence s_commit;
		wr_acc && hit_bod && pwdata[`BROWNOUT_SLEEP_OFF_BIT] && !pwdata[`UNLOCK_BIT] && !core_reset;
	endsequence

	property p_rsv_zero;
		psel && penable && !pwrite && (hit_sleep || hit_gate) |-> prdata[31:8] == 24'h0
			&& (hit_gate ? !prdata[4] : prdata[7:4] == 4'h0);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bits read nonzero");

	property p_mode_field;
		wr_acc && hit_sleep && !core_reset |=> r.mode == $past(pwdata[3:1]);
	endproperty
	a_mode_field: assert property (p_mode_field)
		else $error("mode field did not take the written value");

	property p_sleep_gate;
		sleep_instr && !sleep_active && !core_reset |=> sleep_active == ($past(r.sleep_en)
			&& !$past(mode_reserved));
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("sleep entry disagrees with sleep enable");

	property p_brownout_sleep_off_commit;
		// back-to-back APB writes leave two idle access cycles between the two writes
		s_unlock ##1 (!wr_acc && !core_reset) [*2] ##1 s_commit |=> r.brownout_sleep_off && r.brownout_sleep_off_age == 3'h0;
	endproperty
	a_brownout_sleep_off_commit: assert property (p_brownout_sleep_off_commit)
		else $error("timed sequence failed to set sleep-off");

	property p_brownout_sleep_off_locked;
		s_commit ##0 (!window_open && !r.brownout_sleep_off) |=> !r.brownout_sleep_off;
	endproperty
	a_brownout_sleep_off_locked: assert property (p_brownout_sleep_off_locked)
		else $error("sleep-off set without unlock");

	sequence s_brownout_sleep_off_life;
		!brownout_sleep_off_active [*3] ##1 brownout_sleep_off_active [*3] ##1 !r.brownout_sleep_off;
	endsequence

	property p_brownout_sleep_off_timing;
		disable iff (!presetn || core_reset)
		$rose(r.brownout_sleep_off) |-> s_brownout_sleep_off_life;
	endproperty
	a_brownout_sleep_off_timing: assert property (p_brownout_sleep_off_timing)
		else $error("sleep-off not active for cycles three to five");

	property p_bod_off_entry;
		!sleep_active && sleep_instr && r.sleep_en && !mode_reserved && !core_reset
			|=> brownout_detector_enable == (fuse_bod_en && !$past(brownout_sleep_off_active));
	endproperty
	a_bod_off_entry: assert property (p_bod_off_entry)
		else $error("detector state at sleep entry wrong");

	property p_gate_twi;
		wr_acc && hit_gate && !core_reset |=> two_wire_clk_en == !$past(pwdata[7])
			&& uart_zero_clk_en == !$past(pwdata[1]);
	endproperty
	a_gate_twi: assert property (p_gate_twi)
		else $error("gate write not reflected on clock enables");

	property p_tim2_async;
		timer_two_async_select |-> timer_two_clk_en;
	endproperty
	a_tim2_async: assert property (p_tim2_async)
		else $error("timer two gated while on its own clock");

	property p_conv_refuse;
		wr_acc && hit_gate && converter_enabled && converter_clk_en |=> converter_clk_en;
	endproperty
	a_conv_refuse: assert property (p_conv_refuse)
		else $error("running converter was gated");

	property p_por_reset;
		por_active |-> port_reset ##1 core_reset;
	endproperty
	a_por_reset: assert property (p_por_reset)
		else $error("power-on drop did not reset at once");

	property p_init;
		core_reset |=> r.gate == `CLK_GATE_RST && !r.sleep_en && !r.brownout_sleep_off && !sleep_active;
	endproperty
	a_init: assert property (p_init)
		else $error("registers not at initial value under reset");

	property p_short_dip;
		$rose(bod_low_sync) ##1 !bod_low_sync |-> !r.bod_rst;
	endproperty
	a_short_dip: assert property (p_short_dip)
		else $error("short brown-out dip caused reset");
endmodule

// file: testbench/core_model.sv
// processor core side: APB master for the control registers, sleep and wake strobes
// assumes one pclk domain; all signals change right after a rising edge
`timescale 1ns/1ps
module core_model (
	// clock
	input wire logic pclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core strobes
	output logic sleep_instr,
	output logic wake_event
);
	int timeouts = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sleep_instr = 1'b0;
		wake_event = 1'b0;
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) timeouts++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data flips so a stale lane cannot look valid
		pwdata <= ~d;
	endtask
	// sleep sampled d+2 edges after the call
	task automatic sleep_pulse(input int d);
		repeat (d) @(posedge pclk);
		@(posedge pclk);
		sleep_instr <= 1'b1;
		@(posedge pclk);
		sleep_instr <= 1'b0;
	endtask
	task automatic wake;
		@(posedge pclk);
		wake_event <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
	endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench of the sleep, clock gating and reset block
// assumes core_model as APB master; small filter and timeout values
`timescale 1ns/1ps
`include "power_reset_params.svh"
module testbench;
	import power_reset_pkg::*;
	localparam int unsigned BOD_MIN = 3;
	localparam logic [15:0] TOUT = 16'h0004;
	localparam logic [11:0] A_SLP = 12'(`SLEEP_CTRL_IDX) << 2;
	localparam logic [11:0] A_GATE = 12'(`CLK_GATE_IDX) << 2;
	localparam logic [11:0] A_BOD = 12'(`BOD_CTRL_IDX) << 2;
	localparam logic [11:0] A_STAT = 12'(`STATUS_IDX) << 2;
	logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sleep_instr, wake_event, wd = 1'b0, async_sel = 1'b0, conv_en = 1'b0;
	logic por = 1'b0, pin_n = 1'b1, bo_low = 1'b0, rst_dis = 1'b0;
	logic [2:0] bod_fuse = 3'h2;
	logic core_reset, port_reset, sleep_active, det_en, mux_allow, rst_seen;
	logic [2:0] sleep_mode;
	logic [6:0] ens;
	int n_errors = 0, comparisons = 0;
	initial forever #2.5 pclk = ~pclk;
	always @(posedge pclk or posedge core_reset) if (core_reset === 1'b1) rst_seen <= 1'b1;
	core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_instr(sleep_instr), .wake_event(wake_event));
	sleep_power_reset_control #(.BOD_MIN_CYCLES(BOD_MIN)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_instr(sleep_instr), .wake_event(wake_event),
		.watchdog_reset_pulse(wd), .timer_two_async_select(async_sel),
		.converter_enabled(conv_en), .por_active(por), .ext_reset_pin_n(pin_n),
		.brownout_low(bo_low), .external_reset_disable_fuse(rst_dis),
		.brownout_level_fuse(bod_fuse), .startup_timeout_cycles(TOUT),
		.core_reset(core_reset), .port_reset(port_reset), .sleep_active(sleep_active),
		.sleep_mode(sleep_mode), .brownout_detector_enable(det_en),
		.two_wire_clk_en(ens[6]), .timer_two_clk_en(ens[5]), .timer_zero_clk_en(ens[4]),
		.timer_one_clk_en(ens[3]), .serial_periph_clk_en(ens[2]),
		.uart_zero_clk_en(ens[1]), .converter_clk_en(ens[0]),
		.comparator_mux_allow(mux_allow));
	task automatic give_verdict;
		$display("mismatches %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		core.xfer(1'b1, a, {24'h0, d}, q, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic ex_err);
		logic [31:0] q;
		logic e;
		core.xfer(1'b0, a, 32'h0, q, e);
		check({e, q}, {ex_err, 24'h0, exp});
	endtask
	task automatic wait_low(output int n);
		n = 0;
		while (core_reset !== 1'b0 && n < 200) begin
			@(posedge pclk);
			#1 n++;
		end
		if (n >= 200) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic try_sleep(input int d, input logic [2:0] m, input logic act, input logic det);
		core.sleep_pulse(d);
		#1 check({sleep_active, act ? sleep_mode : 3'h0, det_en}, {act, act ? m : 3'h0, det});
		core.wake();
		#1 check(sleep_active, 1'b0);
	endtask
	// unlock, gap, commit, then sleep d+2 edges after the commit lands
	task automatic brownout_sleep_off(input int gap, input int d, input logic det);
		wr(A_SLP, 8'h05);
		wr(A_BOD, 8'h60);
		repeat (gap) @(posedge pclk);
		wr(A_BOD, 8'h40);
		try_sleep(d, 3'h2, 1'b1, det);
	endtask
	task automatic src(input int s, input int len, input logic exp);
		int n;
		rst_seen = 1'b0;
		wr(A_SLP, 8'h0D);
		@(posedge pclk);
		case (s)
			0: por <= 1'b1;
			1: pin_n <= 1'b0;
			2: wd <= 1'b1;
			default: bo_low <= 1'b1;
		endcase
		#1 if (s < 2) check({port_reset, core_reset}, {exp, exp});
		repeat (len) @(posedge pclk);
		por <= 1'b0;
		pin_n <= 1'b1;
		wd <= 1'b0;
		bo_low <= 1'b0;
		repeat (4) @(posedge pclk);
		check(rst_seen, exp);
		wait_low(n);
		if (s < 2 && exp) check(4 + n, TOUT + 3);
		rd_chk(A_SLP, exp ? 8'h00 : 8'h0D, 1'b0);
	endtask
	initial begin
		int n;
		int ss[7] = '{0, 1, 2, 3, 3, 1, 3};
		int ll[7] = '{2, 2, 1, 8, 1, 3, 8};
		logic [6:0] ee = 7'b0001111;
		logic [7:0] gv[4] = '{8'hFF, 8'h41, 8'hAA, 8'h00};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_low(n);
		rd_chk(A_SLP, `SLEEP_CTRL_RST, 1'b0);
		rd_chk(A_GATE, `CLK_GATE_RST, 1'b0);
		rd_chk(A_BOD, `BOD_CTRL_RST, 1'b0);
		rd_chk(A_STAT, 8'h00, 1'b0);
		rd_chk(12'h100, 8'h00, 1'b1);
		rd_chk(A_SLP + 12'h1, 8'h00, 1'b1);
		for (int i = 0; i < 8; i++) begin
			async_sel <= i[2];
			wr(A_GATE, gv[i[1:0]]);
			rd_chk(A_GATE, gv[i[1:0]] & 8'hEF, 1'b0);
			// outer braces keep the inversion at eight bits
			check({ens, mux_allow}, {~{gv[i[1:0]][7], gv[i[1:0]][6] & ~i[2], gv[i[1:0]][5],
				gv[i[1:0]][3:0], gv[i[1:0]][0]}});
		end
		conv_en <= 1'b1;
		wr(A_GATE, 8'h01);
		rd_chk(A_GATE, 8'h00, 1'b0);
		conv_en <= 1'b0;
		for (int v = 0; v < 16; v++) begin
			wr(A_SLP, {4'hF, v[3:0]});
			rd_chk(A_SLP, {4'h0, v[3:0]}, 1'b0);
			try_sleep(0, v[3:1], v[0] && v[3:2] != 2'b10, 1'b1);
		end
		wr(A_BOD, 8'h40);
		rd_chk(A_BOD, 8'h00, 1'b0);
		// commit lands gap+3 edges after unlock; sleep-off counts for sleeps taken 4..6 edges on
		brownout_sleep_off(0, 2, 1'b0);
		brownout_sleep_off(1, 2, 1'b0);
		brownout_sleep_off(2, 2, 1'b1);
		brownout_sleep_off(0, 1, 1'b1);
		brownout_sleep_off(0, 3, 1'b0);
		brownout_sleep_off(0, 5, 1'b1);
		for (int i = 0; i < 7; i++) begin
			rst_dis <= (i == 5);
			bod_fuse <= (i == 6) ? `BOD_FUSE_OFF : 3'h2;
			src(ss[i], ll[i], ee[i]);
		end
		check(det_en, 1'b0);
		check(core.timeouts, 0);
		give_verdict();
	end
	initial begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		give_verdict();
	end
endmodule
